// ---- hw/fsc_pkg.sv ----
`default_nettype none
package fsc_pkg;
	// ==========================================
	// opcodes seen by the gate
	localparam logic [7:0] OP_HELD_OPERATION_FLAG_A   = 8'h75;
	localparam logic [7:0] OP_HELD_OPERATION_FLAG_B   = 8'hb0;
	localparam logic [7:0] OP_RESUME_A = 8'h7a;
	localparam logic [7:0] OP_RESUME_B = 8'hd0;
	localparam logic [7:0] OP_RD_ARRAY = 8'h03;
	localparam logic [7:0] OP_RD_ID    = 8'h9f;
	localparam logic [7:0] OP_RD_LOCK  = 8'h3c;
	// ==========================================
	// frame geometry
	localparam int         OP_BITS     = 8;
	localparam logic [5:0] CNT_OP_LAST = 6'h07;
	localparam logic [5:0] CNT_OP_DONE = 6'h08;
	localparam logic [5:0] CNT_BLK_LAST = 6'h0f;
	localparam logic [5:0] CNT_MAX     = 6'h3f;
	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS  = 40;
	localparam int HALT_LATENCY_NS = 20000;
	localparam int TIMER_W        = 16;
	// ==========================================
	// operation states, gray along idle-run-halting-held
	typedef enum logic [1:0] {
		FSC_IDLE    = 2'b00,
		FSC_RUN     = 2'b01,
		FSC_HALTING = 2'b11,
		FSC_HELD    = 2'b10
	} fsc_state_t;
endpackage
`default_nettype wire

// ---- hw/fsc_permit.sv ----
`default_nettype none
module fsc_permit
	import fsc_pkg::*;
(
	// opcode under test
	input  wire logic [7:0] opcode,
	// gating flags
	input  wire logic       busy,
	input  wire logic       prog_held,
	input  wire logic       erase_held,
	input  wire logic       suspendable,
	// decision
	output logic            permit,
	output logic            is_held_operation_flag,
	output logic            is_prog
);
	logic held;
	logic idle;

	always_comb begin
		held    = ~busy & (prog_held | erase_held);
		idle    = ~busy & ~prog_held & ~erase_held;
		is_held_operation_flag = 1'b0;
		is_prog = 1'b0;
		case (opcode)
			// honoured in every state
			// status reads, terminate, reset, id reads, wake
			8'h05, 8'h35, 8'h15, 8'h65, 8'hf0, 8'h66, 8'h99,
			8'h9f, 8'h90, 8'h94, 8'hab: begin
				permit = 1'b1;
			end
			8'h75, 8'hb0: begin
				is_held_operation_flag = 1'b1;
				permit  = busy & suspendable;
			end
			8'h7a, 8'hd0: begin
				permit = held;
			end
			// refused while busy
			// reads, wel control, lock status, otp, sfdp, wrap
			8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'he7, 8'h06, 8'h04,
			8'h50, 8'h3c, 8'h3d, 8'h4b, 8'h5a, 8'h77: begin
				permit = idle | held;
			end
			8'h02, 8'ha2, 8'h32, 8'had, 8'haf: begin
				is_prog = 1'b1;
				permit  = idle | (~busy & ~prog_held & erase_held);
			end
			default: begin
				permit = idle;
			end
		endcase
	end
endmodule
`default_nettype wire

// ---- hw/fsc_gate.sv ----
`default_nettype none
module fsc_gate
	import fsc_pkg::*;
#(
	parameter int HALT_NS = HALT_LATENCY_NS
)(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	// serial pins
	input  wire logic       spi_cs_n,
	input  wire logic       spi_sck,
	input  wire logic       spi_si,
	// array engine
	input  wire logic       op_start,
	input  wire logic       op_is_erase,
	input  wire logic [7:0] op_block,
	input  wire logic       op_suspendable,
	input  wire logic       op_done,
	input  wire logic       resume_go,
	output logic            halt_req,
	// command results
	output logic            cmd_valid,
	output logic            cmd_ignored,
	output logic [7:0]      cmd_opcode,
	output logic            prog_block_clash,
	// status flags
	output logic            device_busy_flag,
	output logic            program_suspended_flag,
	output logic            erase_suspended_flag,
	output logic            held_operation_flag
);
	// longest latency rounds down, never below one cycle
	localparam int HALT_CYC_RAW = HALT_NS / CLK_PERIOD_NS;
	localparam int HALT_CYC     = (HALT_CYC_RAW < 1) ? 1 : HALT_CYC_RAW;
	localparam logic [TIMER_W-1:0] HALT_LOAD = TIMER_W'(HALT_CYC - 1);

	// ==========================================
	// pin synchronisers
	logic [2:0] cs_reg, sck_reg, si_reg;
	logic [2:0] cs_next, sck_next, si_next;

	always_comb begin
		cs_next  = {cs_reg[1:0], spi_cs_n};
		sck_next = {sck_reg[1:0], spi_sck};
		si_next  = {si_reg[1:0], spi_si};
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cs_reg  <= 3'h7;
			sck_reg <= 3'h0;
			si_reg  <= 3'h0;
		end else if (ce) begin
			cs_reg  <= cs_next;
			sck_reg <= sck_next;
			si_reg  <= si_next;
		end
	end

	logic cs_rise, active, sck_rise, si_bit;
	assign cs_rise  = cs_reg[1] & ~cs_reg[2];
	assign active   = ~cs_reg[1];
	assign sck_rise = sck_reg[1] & ~sck_reg[2] & active;
	assign si_bit   = si_reg[1];

	// ==========================================
	// serial front end
	logic [5:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] byte_in;
	logic       eighth, blk_edge;
	logic       permit, is_held_operation_flag, is_prog;
	logic       held_operation_flag_pend_reg, held_operation_flag_pend_next;
	logic       chk_reg, chk_next;
	logic       cv_next, ci_next, clash_next;
	logic [7:0] op_next;
	logic       held_operation_flag_go;
	logic [7:0] blk_reg, blk_next;

	assign byte_in  = {sh_reg[6:0], si_bit};
	assign eighth   = sck_rise & (cnt_reg == CNT_OP_LAST);
	assign blk_edge = sck_rise & (cnt_reg == CNT_BLK_LAST);

	fsc_permit u_permit (
		.opcode      (byte_in),
		.busy        (device_busy_flag),
		.prog_held   (program_suspended_flag),
		.erase_held  (erase_suspended_flag),
		.suspendable (op_suspendable),
		.permit      (permit),
		.is_held_operation_flag     (is_held_operation_flag),
		.is_prog     (is_prog)
	);

	always_comb begin
		cnt_next       = cnt_reg;
		sh_next        = sh_reg;
		held_operation_flag_pend_next = held_operation_flag_pend_reg;
		chk_next       = chk_reg;
		cv_next        = 1'b0;
		ci_next        = 1'b0;
		clash_next     = 1'b0;
		op_next        = cmd_opcode;
		if (!active) begin
			cnt_next = 6'h00;
		end else if (sck_rise) begin
			sh_next = byte_in;
			if (cnt_reg != CNT_MAX) begin
				cnt_next = cnt_reg + 6'h01;
			end
		end
		if (eighth) begin
			cv_next = permit;
			ci_next = ~permit;
			op_next = byte_in;
			// either code arms the same request
			held_operation_flag_pend_next = permit & is_held_operation_flag;
			// program in erase suspend needs a block check
			chk_next = permit & is_prog & erase_suspended_flag;
		end
		if (blk_edge && chk_reg) begin
			clash_next = (byte_in == blk_reg);
			chk_next   = 1'b0;
		end
		if (cs_rise) begin
			held_operation_flag_pend_next = 1'b0;
			chk_next       = 1'b0;
		end
	end

	// act at chip select rise, only after exactly one whole byte
	assign held_operation_flag_go = cs_rise & held_operation_flag_pend_reg & (cnt_reg == CNT_OP_DONE);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg          <= 6'h00;
			sh_reg           <= 8'h00;
			held_operation_flag_pend_reg    <= 1'b0;
			chk_reg          <= 1'b0;
			cmd_valid        <= 1'b0;
			cmd_ignored      <= 1'b0;
			cmd_opcode       <= 8'h00;
			prog_block_clash <= 1'b0;
		end else if (ce) begin
			cnt_reg          <= cnt_next;
			sh_reg           <= sh_next;
			held_operation_flag_pend_reg    <= held_operation_flag_pend_next;
			chk_reg          <= chk_next;
			cmd_valid        <= cv_next;
			cmd_ignored      <= ci_next;
			cmd_opcode       <= op_next;
			prog_block_clash <= clash_next;
		end
	end

	// ==========================================
	// operation state
	fsc_state_t         state_reg, state_next;
	logic               kind_reg, kind_next;
	logic               ps_next, es_next, hold_next, busy_next;
	logic [TIMER_W-1:0] tmr_reg, tmr_next;

	always_comb begin
		state_next = state_reg;
		kind_next  = kind_reg;
		ps_next    = program_suspended_flag;
		es_next    = erase_suspended_flag;
		tmr_next   = tmr_reg;
		blk_next   = blk_reg;
		case (state_reg)
			FSC_IDLE: begin
				if (op_start) begin
					state_next = FSC_RUN;
					kind_next  = op_is_erase;
					blk_next   = op_block;
				end
			end
			FSC_RUN: begin
				if (op_done) begin
					// a program inside an erase suspend returns to held
					state_next = (ps_next | es_next) ? FSC_HELD : FSC_IDLE;
				end else if (held_operation_flag_go) begin
					state_next = FSC_HALTING;
					tmr_next   = HALT_LOAD;
				end
			end
			FSC_HALTING: begin
				if (tmr_reg == '0) begin
					state_next = FSC_HELD;
					ps_next    = ps_next | ~kind_reg;
					es_next    = es_next | kind_reg;
				end else begin
					tmr_next = tmr_reg - TIMER_W'(1);
				end
			end
			FSC_HELD: begin
				if (resume_go) begin
					state_next = FSC_RUN;
					// held program resumes before held erase
					kind_next  = ~ps_next;
					if (ps_next) begin
						ps_next = 1'b0;
					end else begin
						es_next = 1'b0;
					end
				end else if (op_start && es_next && !ps_next) begin
					state_next = FSC_RUN;
					kind_next  = 1'b0;
				end
			end
			default: begin
				state_next = FSC_IDLE;
			end
		endcase
		// flags that pick the gating column
		busy_next = (state_next == FSC_RUN) || (state_next == FSC_HALTING);
		hold_next = ps_next | es_next;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg              <= FSC_IDLE;
			kind_reg               <= 1'b0;
			tmr_reg                <= '0;
			blk_reg                <= 8'h00;
			device_busy_flag       <= 1'b0;
			program_suspended_flag <= 1'b0;
			erase_suspended_flag   <= 1'b0;
			held_operation_flag    <= 1'b0;
		end else if (ce) begin
			state_reg              <= state_next;
			kind_reg               <= kind_next;
			tmr_reg                <= tmr_next;
			blk_reg                <= blk_next;
			device_busy_flag       <= busy_next;
			program_suspended_flag <= ps_next;
			erase_suspended_flag   <= es_next;
			held_operation_flag    <= hold_next;
		end
	end

	assign halt_req = (state_reg == FSC_HALTING);

	// ==========================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	property p_held_operation_flag_codes;
		ce && eighth && (byte_in == OP_HELD_OPERATION_FLAG_A || byte_in == OP_HELD_OPERATION_FLAG_B)
			&& device_busy_flag && op_suspendable |=> cmd_valid;
	endproperty
	a_held_operation_flag_codes: assert property (p_held_operation_flag_codes) else $error("suspend code refused");

	property p_refused_inert;
		ce && eighth && !permit |=> !held_operation_flag_pend_reg && !chk_reg;
	endproperty
	a_refused_inert: assert property (p_refused_inert) else $error("refused opcode armed");
	property p_bit_count;
		ce && (cv_next || ci_next) |-> cnt_reg == CNT_OP_LAST && sck_rise;
	endproperty
	a_bit_count: assert property (p_bit_count) else $error("decision off eighth bit");

	property p_start_on_cs;
		ce && state_reg == FSC_RUN && !op_done && held_operation_flag_go |=> state_reg == FSC_HALTING;
	endproperty
	a_start_on_cs: assert property (p_start_on_cs) else $error("suspend not started");

	property p_no_early;
		ce && state_reg == FSC_RUN && !cs_rise |=> state_reg != FSC_HALTING;
	endproperty
	a_no_early: assert property (p_no_early) else $error("suspend before cs rise");

	property p_busy_read;
		ce && eighth && byte_in == OP_RD_ARRAY && device_busy_flag |=> cmd_ignored && !cmd_valid;
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("read passed while busy");

	property p_id_any;
		ce && eighth && byte_in == OP_RD_ID |=> cmd_valid;
	endproperty
	a_id_any: assert property (p_id_any) else $error("id read refused");

	property p_lock_rd;
		ce && eighth && byte_in == OP_RD_LOCK |=> cmd_valid == !$past(device_busy_flag);
	endproperty
	a_lock_rd: assert property (p_lock_rd) else $error("lock status gating wrong");

	property p_halt_done;
		$rose(halt_req) |-> ##[1:1000] (held_operation_flag && !device_busy_flag);
	endproperty
	a_halt_done: assert property (p_halt_done) else $error("halt never completed");

	property p_whole_byte;
		ce && cs_rise && held_operation_flag_pend_reg && cnt_reg != CNT_OP_DONE |=> !halt_req;
	endproperty
	a_whole_byte: assert property (p_whole_byte) else $error("suspend on partial frame");

	property p_idle_held_operation_flag;
		ce && eighth && (byte_in == OP_HELD_OPERATION_FLAG_A || byte_in == OP_HELD_OPERATION_FLAG_B)
			&& !device_busy_flag |=> cmd_ignored;
	endproperty
	a_idle_held_operation_flag: assert property (p_idle_held_operation_flag) else $error("suspend passed while idle");

	property p_clash_es;
		prog_block_clash |-> erase_suspended_flag;
	endproperty
	a_clash_es: assert property (p_clash_es) else $error("clash outside erase suspend");

	c_suspend:  cover property (halt_req ##[1:1000] held_operation_flag);
	c_ignored:  cover property (cmd_ignored);
	c_clash:    cover property (prog_block_clash);
	c_nested:   cover property (device_busy_flag && erase_suspended_flag);
endmodule
`default_nettype wire

// ---- bench/fsc_host_model.sv ----
`default_nettype none
module fsc_host_model (
	// clock
	input  wire logic sys_clk,
	// serial pins
	output var logic  spi_cs_n,
	output var logic  spi_sck,
	output var logic  spi_si
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 8;
	logic idle = 1'b1;
	initial begin
		spi_cs_n = 1'b1;
		spi_sck  = 1'b0;
		spi_si   = 1'b0;
	end
	// ==========================================
	// released data line wanders so a stale bit never reads as data
	always @(negedge sys_clk)
		if (idle)
			spi_si <= ~spi_si;
	// ==========================================
	// opcode msb first, sck still outside frames
	task automatic frame(input logic [23:0] d, input int nbits);
		@(negedge sys_clk);
		idle = 1'b0;
		spi_cs_n <= 1'b0;
		repeat (4) @(negedge sys_clk);
		for (int i = 0; i < nbits; i++) begin
			spi_si <= d[23 - i];
			repeat (HALF) @(negedge sys_clk);
			spi_sck <= 1'b1;
			repeat (HALF) @(negedge sys_clk);
			spi_sck <= 1'b0;
		end
		repeat (HALF) @(negedge sys_clk);
		// off-boundary bit counts are sent on purpose by the bench
		spi_cs_n <= 1'b1;
		idle = 1'b1;
		repeat (8) @(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

// ---- bench/fsc_gate_tb_top.sv ----
`default_nettype none
module fsc_gate_tb_top
	import fsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       sys_clk = 1'b0;
	logic       rstn = 1'b0;
	logic       spi_cs_n, spi_sck, spi_si, halt_req, cmd_valid, cmd_ignored, prog_block_clash;
	logic       op_start = 1'b0, op_is_erase = 1'b0, op_done = 1'b0, resume_go = 1'b0;
	logic       op_suspendable = 1'b1, ce = 1'b1;
	logic [7:0] op_block = 8'h00, blk = 8'h00, cmd_opcode;
	logic [3:0] fl;
	int         err_count = 0, total_checks = 0, n_ok = 0, n_ign = 0, n_clash = 0, n_halt = 0;
	int         m_busy = 0, m_ps = 0, m_es = 0, m_run = 0;
	localparam logic [7:0] OPS [51] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'he7, 8'h20, 8'h52,
		8'hd8, 8'h60, 8'hc7, 8'h02, 8'ha2, 8'h32, 8'had, 8'haf, 8'h75, 8'hb0, 8'h7a, 8'hd0, 8'h06,
		8'h04, 8'h50, 8'h36, 8'h39, 8'h7e, 8'h98, 8'h3c, 8'h3d, 8'h9b, 8'h4b, 8'h05, 8'h35, 8'h15,
		8'h65, 8'h01, 8'h31, 8'h11, 8'h71, 8'h6f, 8'hf0, 8'h66, 8'h99, 8'h9f, 8'h90, 8'h94, 8'hb9,
		8'hab, 8'h79, 8'h5a, 8'h77};
	always #20 sys_clk = ~sys_clk;
	fsc_gate #(.HALT_NS(400)) fsc_gate_inst (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
		.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si), .op_start(op_start),
		.op_is_erase(op_is_erase), .op_block(op_block), .op_suspendable(op_suspendable),
		.op_done(op_done), .resume_go(resume_go), .halt_req(halt_req), .cmd_valid(cmd_valid),
		.cmd_ignored(cmd_ignored), .cmd_opcode(cmd_opcode), .prog_block_clash(prog_block_clash),
		.device_busy_flag(fl[3]), .program_suspended_flag(fl[2]),
		.erase_suspended_flag(fl[1]), .held_operation_flag(fl[0]));
	fsc_host_model fsc_host_model_inst (.sys_clk(sys_clk), .spi_cs_n(spi_cs_n),
		.spi_sck(spi_sck), .spi_si(spi_si));
	// ==========================================
	// pulse counters, so no pulse is missed between samples
	always @(posedge sys_clk) begin
		n_ok    <= n_ok + int'(cmd_valid === 1'b1);
		n_ign   <= n_ign + int'(cmd_ignored === 1'b1);
		n_clash <= n_clash + int'(prog_block_clash === 1'b1);
		n_halt  <= n_halt + int'(halt_req === 1'b1);
	end
	// ==========================================
	// reference gating model
	function automatic int allowed(input logic [7:0] op);
		case (op)
			8'h05, 8'h35, 8'h15, 8'h65, 8'hf0, 8'h66, 8'h99, 8'h9f, 8'h90, 8'h94, 8'hab: return 1;
			8'h75, 8'hb0: return int'(m_busy != 0 && op_suspendable === 1'b1);
			8'h7a, 8'hd0: return int'(m_busy == 0 && (m_ps | m_es) != 0);
			8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'he7, 8'h06, 8'h04, 8'h50, 8'h3c, 8'h3d, 8'h4b,
			8'h5a, 8'h77:
				return int'(m_busy == 0);
			8'h02, 8'ha2, 8'h32, 8'had, 8'haf: return int'(m_busy == 0 && m_ps == 0);
			default: return int'((m_busy | m_ps | m_es) == 0);
		endcase
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic flags();
		logic [7:0] e;
		e = 8'({m_busy[0], m_ps[0], m_es[0], m_ps[0] | m_es[0]});
		chk({4'h0, fl}, e);
	endtask
	task automatic send(input logic [7:0] op, input logic [7:0] a, input int nbits);
		int v0;
		int i0;
		v0 = n_ok;
		i0 = n_ign;
		fsc_host_model_inst.frame({op, a, 8'h00}, nbits);
		chk(8'(n_ok - v0), 8'(allowed(op)));
		chk(8'(n_ign - i0), 8'(1 - allowed(op)));
		chk(cmd_opcode, op);
	endtask
	task automatic ev(input int k);
		@(negedge sys_clk);
		op_start = (k == 0);
		op_done = (k == 1);
		resume_go = (k == 2);
		@(negedge sys_clk);
		{op_start, op_done, resume_go} = 3'b000;
		@(negedge sys_clk);
		if (k == 0) begin
			m_busy = 1;
			m_run = int'(op_is_erase);
		end else if (k == 1)
			m_busy = 0;
		else if (m_ps != 0) begin
			{m_ps, m_busy, m_run} = {32'd0, 32'd1, 32'd0};
		end else if (m_es != 0)
			{m_es, m_busy, m_run} = {32'd0, 32'd1, 32'd1};
		flags();
	endtask
	// every opcode with nine bits: judged, but never a byte-boundary release
	task automatic sweep(input string name);
		int h0;
		int r;
		h0 = n_halt;
		r = $urandom_range(50);
		for (int i = 0; i < 51; i++)
			send(OPS[(i + r) % 51], ~blk, 9);
		chk(8'(n_halt - h0), 8'h00);
		flags();
		$display("test %s done", name);
	endtask
	task automatic suspend(input logic [7:0] op);
		int h0;
		h0 = n_halt;
		send(op, blk, 8);
		for (int i = 0; i < 100 && (halt_req !== 1'b0 || fl[3] !== 1'b0); i++)
			@(negedge sys_clk);
		if (halt_req !== 1'b0) begin
			err_count++;
			report_and_stop();
		end
		chk(8'(n_halt - h0 inside {[9:11]}), 8'h01);
		if (m_run != 0)
			m_es = 1;
		else
			m_ps = 1;
		m_busy = 0;
		flags();
		$display("test suspend %h done", op);
	endtask
	// ==========================================
	initial begin
		void'($urandom(32'ha85b1e76));
		repeat (16) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (4) @(negedge sys_clk);
		flags();
		chk(cmd_opcode, 8'h00);
		sweep("idle");
		blk = 8'($urandom);
		op_block = blk;
		op_is_erase = 1'b1;
		ev(0);
		sweep("erase busy");
		op_suspendable = 1'b0;
		send(8'h75, blk, 8);
		op_suspendable = 1'b1;
		flags();
		suspend(8'hb0);
		// engine pulses are lost while the clock enable is low
		ce = 1'b0;
		resume_go = 1'b1;
		repeat (3) @(negedge sys_clk);
		{ce, resume_go} = 2'b10;
		flags();
		$display("test freeze done");
		sweep("erase held");
		begin
			int c0;
			c0 = n_clash;
			send(8'h02, blk, 24);
			chk(8'(n_clash - c0), 8'h01);
			send(8'h02, blk ^ 8'h01, 24);
			chk(8'(n_clash - c0), 8'h01);
			$display("test clash done");
		end
		op_is_erase = 1'b0;
		ev(0);
		sweep("nested program busy");
		suspend(8'h75);
		sweep("both held");
		ev(2);
		ev(1);
		ev(2);
		ev(1);
		$display("test resume order done");
		report_and_stop();
	end
endmodule
`default_nettype wire
